// [design/tdcr_pkg.sv]
// Purpose: Shared constants and carriers for the threshold / DC-removal /
//          channel 0 configuration register bank.
// Assumes: APB slave, 32-bit data, 16-bit registers in the low half.
// Notes:   Printed offsets are word indices; byte address is index * 4.
package tdcr_pkg;

  localparam logic [11:0] TDCR_IDX_TH_HIGH = 12'h007;
  localparam logic [11:0] TDCR_IDX_TH_LOW  = 12'h008;
  localparam logic [11:0] TDCR_IDX_CHANNEL_ZERO_CONFIG = 12'h009;
  localparam logic [11:0] TDCR_IDX_CD_CTRL = 12'h020;
  localparam logic [11:0] TDCR_IDX_STATUS  = 12'h021;

  localparam logic [15:0] TDCR_RST_REG  = 16'h0000;
  localparam logic [15:0] TDCR_MASK_LOW = 16'hff0f;
  localparam logic [15:0] TDCR_MASK_CH0 = 16'hffc7;
  localparam logic [15:0] TDCR_MASK_CD  = 16'h0071;

  localparam int TDCR_COEF_LSB  = 0;
  localparam int TDCR_COEF_MSB  = 3;
  localparam int TDCR_THL_LSB   = 8;
  localparam int TDCR_PHASE_LSB = 6;
  localparam int TDCR_DCOFF_BIT = 2;
  localparam int TDCR_CDEN_BIT  = 0;
  localparam int TDCR_CDNUM_LSB = 4;

  localparam logic [3:0] TDCR_COEF_OFF = 4'h0;
  localparam logic [7:0] TDCR_CNT_ONE  = 8'h01;

  typedef enum logic [1:0] {
    TDCR_IN_PINS  = 2'h0,
    TDCR_IN_SHORT = 2'h1,
    TDCR_IN_POS   = 2'h2,
    TDCR_IN_NEG   = 2'h3
  } tdcr_input_t;

  typedef struct packed {
    logic [15:0] thHigh;
    logic [15:0] thLow;
    logic [15:0] ch0Cfg;
    logic [15:0] cdCtrl;
  } tdcr_regs_t;

  typedef struct packed {
    logic [23:0] threshold;
    logic [3:0]  coefCode;
    logic        filterOn;
    logic [4:0]  coefShift;
    logic [9:0]  phaseDelay;
    logic        ch0FilterOn;
    tdcr_input_t inputSel;
  } tdcr_cfg_t;

endpackage

// [design/tdcr_detect.sv]
// Purpose: Counts threshold exceedances and raises the detect flag.
// Assumes: resultValid pulses once per conversion result.
// Notes:   Flag is sticky; a new detect wins over a clear in one cycle.
`timescale 1ns/1ps
module tdcr_detect
  import tdcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic [2:0]  countSel,
  input  wire logic [23:0] threshold,
  input  wire logic        resultValid,
  input  wire logic [23:0] resultMag,
  input  wire logic        clearFlag,
  output logic             detectFlag
);

  typedef struct packed {
    logic [7:0] hits;
    logic       flag;
  } tdcr_det_state_t;

  tdcr_det_state_t st_q;
  tdcr_det_state_t st_d;
  logic [7:0]      needed;
  logic            exceed;

  always_comb begin
    needed = TDCR_CNT_ONE << countSel;
    exceed = resultValid && (resultMag > threshold);
    st_d   = st_q;
    if (clearFlag) begin
      st_d.flag = 1'b0;
    end
    if (!enable) begin
      st_d.hits = 8'h00;
    end else if (exceed) begin
      if (st_q.hits + TDCR_CNT_ONE >= needed) begin
        st_d.flag = 1'b1;
        st_d.hits = 8'h00;
      end else begin
        st_d.hits = st_q.hits + TDCR_CNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign detectFlag = st_q.flag;

endmodule // tdcr_detect

// [design/tdcr_regs.sv]
// What this block does
// - Index 7h holds the 16-bit upper threshold, read-write, reset zero.
// - Index 8h bits 15:8 hold the lower threshold byte, reset zero.
// - The global DC-removal code comes from index 8h bits 3:0, reset zero.
// - Code zero turns the filter off; codes 1..15 give 1/4 down to 1/65536.
// - Channel 0 phase delay is a signed 10-bit count in bits 15:6.
// - Bit 2 clear follows the global code; set turns channel 0 filter off.
// - Bits 1:0 pick pins, shorted, positive or negative DC test input.
// - Channel 0 config at index 9h resets to all zeros.
// - Detect fires after 1 to 128 (power of two) exceedances.
//
// Purpose: APB register bank driving threshold, filter and channel 0 setup.
// Assumes: APB3, zero wait states, byte address = index * 4.
// Notes:   Reserved bits read zero; unmapped addresses answer pslverr.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module tdcr_regs
  import tdcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        resultValid,
  input  wire logic [23:0] resultMag,
  output tdcr_cfg_t        cfg,
  output logic             detectFlag
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    tdcr_regs_t  regs;
    logic [31:0] rdata;
    logic        err;
  } tdcr_state_t;

  tdcr_state_t st_q;
  tdcr_state_t st_d;
  logic [11:0] index;
  logic        access;
  logic        wrEn;
  logic        clearDet;
  logic        detRaw;
  logic [15:0] wdata;

  function automatic logic known(input logic [11:0] idx);
    known = (idx == TDCR_IDX_TH_HIGH) || (idx == TDCR_IDX_TH_LOW) ||
            (idx == TDCR_IDX_CHANNEL_ZERO_CONFIG) || (idx == TDCR_IDX_CD_CTRL) ||
            (idx == TDCR_IDX_STATUS);
  endfunction

  assign index    = paddr[13:2];
  assign access   = psel && penable;
  assign wrEn     = access && pwrite;
  assign wdata    = pwdata[15:0];
  // Status write with bit 0 set clears the detect flag
  assign clearDet = wrEn && (index == TDCR_IDX_STATUS) &&
                    pwdata[TDCR_CDEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (wrEn) begin
      case (index)
        TDCR_IDX_TH_HIGH: st_d.regs.thHigh = wdata;
        TDCR_IDX_TH_LOW:  st_d.regs.thLow = wdata & TDCR_MASK_LOW;
        // Reserved bits are masked so stray host writes cannot stick
        TDCR_IDX_CHANNEL_ZERO_CONFIG: st_d.regs.ch0Cfg = wdata & TDCR_MASK_CH0;
        TDCR_IDX_CD_CTRL: st_d.regs.cdCtrl = wdata & TDCR_MASK_CD;
        default:          st_d.regs = st_q.regs;
      endcase
    end
    // Read data is captured in setup so prdata comes from a flop
    if (psel && !penable && !pwrite) begin
      case (index)
        TDCR_IDX_TH_HIGH: st_d.rdata = {16'h0000, st_q.regs.thHigh};
        TDCR_IDX_TH_LOW:  st_d.rdata = {16'h0000, st_q.regs.thLow};
        TDCR_IDX_CHANNEL_ZERO_CONFIG: st_d.rdata = {16'h0000, st_q.regs.ch0Cfg};
        TDCR_IDX_CD_CTRL: st_d.rdata = {16'h0000, st_q.regs.cdCtrl};
        TDCR_IDX_STATUS:  st_d.rdata = {31'h00000000, detRaw};
        default:          st_d.rdata = 32'h00000000;
      endcase
    end
    if (psel && !penable) begin
      st_d.err = !known(index);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.regs  <= {TDCR_RST_REG, TDCR_RST_REG,
                     TDCR_RST_REG, TDCR_RST_REG};
      st_q.rdata <= 32'h00000000;
      st_q.err   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = access && st_q.err;

  ////////////////////////////////////////////////////////////////////////////
  // Config decode for the datapath
  always_comb begin
    cfg.threshold = {st_q.regs.thHigh,
                     st_q.regs.thLow[15:TDCR_THL_LSB]};
    cfg.coefCode  = st_q.regs.thLow[TDCR_COEF_MSB:TDCR_COEF_LSB];
    cfg.filterOn  = (cfg.coefCode != TDCR_COEF_OFF);
    // Coefficient is 2^-(code+1); code 1 gives a shift of 2
    cfg.coefShift = {1'b0, cfg.coefCode} + 5'h01;
    cfg.phaseDelay = st_q.regs.ch0Cfg[15:TDCR_PHASE_LSB];
    cfg.ch0FilterOn = cfg.filterOn &&
                      !st_q.regs.ch0Cfg[TDCR_DCOFF_BIT];
    cfg.inputSel = tdcr_input_t'(st_q.regs.ch0Cfg[1:0]);
  end

  tdcr_detect u_detect (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .enable      (st_q.regs.cdCtrl[TDCR_CDEN_BIT]),
    .countSel    (st_q.regs.cdCtrl[TDCR_CDNUM_LSB +: 3]),
    .threshold   (cfg.threshold),
    .resultValid (resultValid),
    .resultMag   (resultMag),
    .clearFlag   (clearDet),
    .detectFlag  (detRaw)
  );

  assign detectFlag = detRaw;

endmodule // tdcr_regs

// [verification/tdcr_regs_asserts.sv]
// Purpose: port checks for the register bank
// Assumes: byte address is index * 4
// Notes: count depth is left to the bench
`timescale 1ns/1ps
module tdcr_regs_asserts
  import tdcr_pkg::*;
(
  input logic        core_clk,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        resultValid,
  input logic [13:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [23:0] resultMag,
  input tdcr_cfg_t   cfg,
  input logic        detectFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire wr = psel && penable && pwrite;
  thr_high_a: assert property (wr && paddr == 14'h1c |=>
    cfg.threshold[23:8] == $past(pwdata[15:0])) else $error("high");
  thr_low_a: assert property (wr && paddr == 14'h20 |=>
    {cfg.threshold[7:0], cfg.coefCode} == $past({pwdata[15:8], pwdata[3:0]}))
    else $error("low");
  coef_off_a: assert property (wr && paddr == 14'h20 |=>
    cfg.filterOn == ($past(pwdata[3:0]) != 4'h0)) else $error("off");
  coef_shift_a: assert property (cfg.filterOn |->
    cfg.coefShift == 5'(cfg.coefCode) + 5'h01) else $error("shift");
  phase_sel_a: assert property (wr && paddr == 14'h24 |=>
    {cfg.phaseDelay, cfg.inputSel} == $past({pwdata[15:6], pwdata[1:0]}))
    else $error("ch0");
  ch0_off_a: assert property (wr && paddr == 14'h24 |=>
    cfg.ch0FilterOn == (cfg.filterOn && !$past(pwdata[2]))) else $error("dc");
  reset_zero_a: assert property ($rose(rst_n) |->
    {cfg.threshold, cfg.phaseDelay, cfg.inputSel} == '0) else $error("rst");
  detect_why_a: assert property ($rose(detectFlag) |->
    $past(resultValid && resultMag > cfg.threshold)) else $error("det");
  read_zero_a: assert property (psel && penable && !pwrite |->
    prdata[31:16] == 16'h0000 && (paddr != 14'h24 || prdata[5:3] == 3'h0))
    else $error("resv");
  flag_hold_a: assert property (detectFlag &&
    !(wr && paddr == 14'h84 && pwdata[0]) |=> detectFlag) else $error("hold");
  flag_clear_a: assert property (wr && paddr == 14'h84 &&
    pwdata[0] && !(resultValid && resultMag > cfg.threshold) |=> !detectFlag)
    else $error("clear");
endmodule // tdcr_regs_asserts
bind tdcr_regs tdcr_regs_asserts u_chk (
  .core_clk    (core_clk),
  .rst_n       (rst_n),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .resultValid (resultValid),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .prdata      (prdata),
  .resultMag   (resultMag),
  .cfg         (cfg),
  .detectFlag  (detectFlag)
);

// [verification/tdcr_host.sv]
// Purpose: APB host model
// Assumes: a transfer starts just after a rising edge
// Notes: one idle cycle follows every transfer
`timescale 1ns/1ps
module tdcr_host
  import tdcr_pkg::*;
(
  input logic         core_clk,
  input logic         pready,
  input logic         pslverr,
  input logic [31:0]  prdata,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [13:0] paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(logic w, logic [13:0] a, logic [31:0] d,
                      output logic [32:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= a == 14'h24 ? d & 32'(TDCR_MASK_CH0) : d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (!pready);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule // tdcr_host

// [verification/testbench.sv]
// Purpose: self-checking bench for the register bank
// Assumes: the host model drives APB
// Notes: fields come from a shift register seeded at 12
`timescale 1ns/1ps
module testbench import tdcr_pkg::*;;
  logic        core_clk = 0, rst_n = 0, resultValid = 0;
  logic        psel, penable, pwrite, pready, pslverr, detectFlag;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] rd;
  logic [23:0] resultMag = '0;
  logic [15:0] s = 16'h000c, h, l, c;
  logic [3:0]  k;
  tdcr_cfg_t   cfg;
  int          failCount = 0, compares = 0;
  always #50 core_clk = ~core_clk;
  tdcr_regs u_tdcr_regs (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .resultValid (resultValid),
    .resultMag   (resultMag),
    .cfg         (cfg),
    .detectFlag  (detectFlag)
  );
  tdcr_host u_host (
    .core_clk (core_clk),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata)
  );
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [12:0] ch0x(logic [15:0] v, logic [3:0] g);
    return {v[15:6], g != 4'h0 && !v[2], v[1:0]};
  endfunction
  task automatic chk(logic [39:0] g, logic [39:0] e);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("mismatches=%0d compares=%0d", failCount, compares);
    if (failCount == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(logic [13:0] a, logic [15:0] d);
    u_host.xfer(1'b1, a, {16'h0, d}, rd);
  endtask
  // Reset values seen over the bus and at the config outputs
  task automatic zchk;
    for (int a = 7; a <= 9; a++) begin
      u_host.xfer(1'b0, 14'(a * 4), '0, rd);
      chk(rd, 40'h0000000000);
    end
    chk({cfg.threshold, cfg[12:0], detectFlag}, 40'h0000000000);
  endtask
  // Flag is looked at mid-cycle so the edge updates have landed
  task automatic pulse(logic [23:0] m, logic e);
    resultValid <= 1'b1;
    resultMag <= m;
    @(posedge core_clk);
    resultValid <= 1'b0;
    @(negedge core_clk);
    chk(detectFlag, e);
    @(posedge core_clk);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    zchk();
    for (int i = 0; i < 16; i++) begin
      s = nx(s);
      h = s;
      l = {s[7:0], s[15:12], 4'(i)};
      c = {s[11:0], 1'b0, 3'(i)};
      k = l[3:0];
      wr(14'h1c, h);
      wr(14'h20, l);
      wr(14'h24, c);
      u_host.xfer(1'b0, 14'h20, '0, rd);
      chk(rd, l & TDCR_MASK_LOW);
      u_host.xfer(1'b0, 14'h1c, '0, rd);
      chk(rd, h);
      u_host.xfer(1'b0, 14'h24, '0, rd);
      chk(rd, c & TDCR_MASK_CH0);
      chk(cfg.threshold, {h, l[15:8]});
      chk({cfg.filterOn, cfg.coefShift}, {k != 0, 5'(k) + 5'h1});
      chk(cfg[12:0], ch0x(c, k));
    end
    u_host.xfer(1'b0, 14'h40, '0, rd);
    chk(rd, 33'h100000000);
    wr(14'h1c, 16'h0001);
    wr(14'h20, 16'h8000);
    wr(14'h80, 16'h0011);
    pulse(24'h000180, 1'b0);
    pulse(24'h000181, 1'b0);
    pulse(24'h000181, 1'b1);
    wr(14'h84, 16'h0001);
    wr(14'h80, 16'h0071);
    for (int n = 1; n <= 128; n++) pulse(24'hffffff, n == 128);
    u_host.xfer(1'b0, 14'h84, '0, rd);
    chk(rd, 40'h0000000001);
    wr(14'h84, 16'h0001);
    u_host.xfer(1'b0, 14'h84, '0, rd);
    chk(rd, 40'h0000000000);
    // Detect and clear meet at one edge: the detect must win
    wr(14'h80, 16'h0001);
    fork
      wr(14'h84, 16'h0001);
      begin
        @(posedge core_clk);
        resultValid <= 1'b1;
        @(posedge core_clk);
        resultValid <= 1'b0;
      end
    join
    chk(detectFlag, 1'b1);
    // Second reset in mid-run must bring indices 7h to 9h, the threshold and channel 0 config outputs and the detect flag back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    zchk();
    final_report();
  end
  initial begin
    #3000000;
    failCount++;
    final_report();
  end
endmodule // testbench
